//--- hw/spi_defs.vh
// Register map, field positions, reset values and divider constants of the SPI FIFO controller.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef SPI_DEFS_VH
`define SPI_DEFS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define REG_CFG       8'ha1
`define REG_MODE      8'ha2
`define REG_STAT      8'ha3
`define REG_DATA      8'ha4
`define REG_IRQ       8'ha5
`define REG_MASK      8'ha6

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define CFG_RESET     8'h20
`define CFG_IE        7
`define CFG_EN        6
`define CFG_MST       5
`define CFG_CPOL      4
`define CFG_CPHA      3
`define CFG_SCKE      2
`define CFG_DFLT      1
`define CFG_SFLT      0

// ----------------------------------------------------------------
// Mode control register fields
// ----------------------------------------------------------------
`define MODE_RESET    8'h00
`define MODE_WMASK    8'hcf
`define MODE_THR_HI   7
`define MODE_THR_LO   6
`define MODE_FLUSH    5
`define MODE_RATE_HI  3
`define MODE_RATE_LO  1
`define MODE_DIR      0

// ----------------------------------------------------------------
// Status register and interrupt register fields
// ----------------------------------------------------------------
`define STAT_RESET    8'h00
`define STAT_DONE     7
`define STAT_RX_OVERRUN_FLAG     6
`define STAT_TX_OVERRUN_FLAG     5
`define STAT_TX_UNDERRUN_FLAG     4
`define STAT_RX_FIFO_FULL    3
`define STAT_RX_FIFO_EMPTY    2
`define STAT_TX_FIFO_FULL    1
`define STAT_TX_FIFO_EMPTY    0
`define IRQ_RESET     4'h0
`define IRQ_DONE      0
`define IRQ_RX_OVERRUN_FLAG      1
`define IRQ_TX_OVERRUN_FLAG      2
`define IRQ_TX_UNDERRUN_FLAG      3

// ----------------------------------------------------------------
// Serial clock half periods in system clocks, and byte framing
// ----------------------------------------------------------------
`define HALF_DIV4     8'h02
`define HALF_DIV6     8'h03
`define HALF_DIV8     8'h04
`define HALF_DIV16    8'h08
`define HALF_DIV32    8'h10
`define HALF_DIV64    8'h20
`define HALF_DIV128   8'h40
`define HALF_DIV256   8'h80
`define LAST_EDGE     4'hf
`define LAST_BIT      3'h7
`define IDLE_BYTE     8'hff
`define PINS_IDLE     4'h8
`define FIFO_DEPTH    4

`endif

//--- hw/byte_fifo.v
// Small synchronous FIFO holding bytes between the register port and the shifter.
// Assumes one clock; push while full and pop while empty are ignored inside the FIFO itself.
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             clr,
  input  wire             push,
  input  wire [WIDTH-1:0] wdata,
  input  wire             pop,
  output wire [WIDTH-1:0] rdata,
  output wire             full,
  output wire             empty
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;

  wire do_push = push & ~full;
  wire do_pop  = pop & ~empty;

  assign rdata = mem[rp_reg];
  assign full  = (cnt_reg == DEPTH[AW:0]);
  assign empty = (cnt_reg == {(AW+1){1'b0}});

  always @(posedge clk) begin
    if (do_push) begin
      mem[wp_reg] <= wdata;
    end
  end

  // Flush wins over a simultaneous push or pop so software sees a clean empty FIFO.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wp_reg <= (wp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
      end
      if (do_pop) begin
        rp_reg <= (rp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule // byte_fifo

`default_nettype wire

//--- hw/spi_fifo_controller.v
// SPI master/slave controller with byte FIFOs, rate divider and flag/interrupt logic.
// Assumes a single 125 MHz clock; all pin inputs arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "spi_defs.vh"

module spi_fifo_controller #(
  parameter DEPTH = `FIFO_DEPTH
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  output wire       irq,
  input  wire       sck_in,
  output wire       sck_out,
  output wire       sck_oe,
  input  wire       mosi_in,
  output wire       mosi_out,
  output wire       mosi_oe,
  input  wire       miso_in,
  output wire       miso_out,
  output wire       miso_oe,
  input  wire       ss_n_in,
  output wire       ss_n_out,
  output wire       ss_n_oe
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function [7:0] rate_half;
    input [2:0] code;
    begin
      case (code)
        3'h0: rate_half = `HALF_DIV4;
        3'h1: rate_half = `HALF_DIV6;
        3'h2: rate_half = `HALF_DIV8;
        3'h3: rate_half = `HALF_DIV16;
        3'h4: rate_half = `HALF_DIV32;
        3'h5: rate_half = `HALF_DIV64;
        3'h6: rate_half = `HALF_DIV128;
        default: rate_half = `HALF_DIV256;
      endcase
    end
  endfunction

  function [7:0] shift_in;
    input [7:0] sh;
    input       b;
    input       msb;
    begin
      shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
    end
  endfunction

  function head_bit;
    input [7:0] sh;
    input       msb;
    begin
      head_bit = msb ? sh[7] : sh[0];
    end
  endfunction

  localparam ST_IDLE  = 2'h0;
  localparam ST_MRUN  = 2'h1;
  localparam ST_SLAVE = 2'h2;
  localparam [3:0] PIN_IDLE = `PINS_IDLE;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0] cfg_reg;
  reg  [7:0] mode_reg;
  reg        done_reg;
  reg        rx_overrun_flag_reg;
  reg        tx_overrun_flag_reg;
  reg        tx_underrun_flag_reg;
  reg  [3:0] irq_stat_reg;
  reg  [3:0] irq_mask_reg;
  reg  [1:0] st_reg;
  reg  [7:0] div_reg;
  reg  [3:0] edge_reg;
  reg  [2:0] bit_reg;
  reg  [1:0] thr_cnt_reg;
  reg  [7:0] tx_sh_reg;
  reg  [7:0] rx_sh_reg;
  reg        out_reg;
  reg        phase_reg;
  reg        ss_reg;
  reg        sck_prev_reg;
  reg  [3:0] sync1_reg;
  reg  [3:0] sync2_reg;
  reg  [3:0] hist_reg;
  reg  [3:0] filt_reg;

  wire       en     = cfg_reg[`CFG_EN];
  wire       master = cfg_reg[`CFG_MST];
  wire       cpol   = cfg_reg[`CFG_CPOL];
  wire       cpha   = cfg_reg[`CFG_CPHA];
  wire       msb    = mode_reg[`MODE_DIR];
  wire [1:0] thr    = {mode_reg[`MODE_THR_HI], mode_reg[`MODE_THR_LO]};
  wire [7:0] half   = rate_half(mode_reg[`MODE_RATE_HI:`MODE_RATE_LO]);

  wire wr_cfg  = wr && (addr == `REG_CFG);
  wire wr_mode = wr && (addr == `REG_MODE);
  wire wr_stat = wr && (addr == `REG_STAT);
  wire wr_data = wr && (addr == `REG_DATA);
  wire wr_mask = wr && (addr == `REG_MASK);
  wire rd_data = rd && (addr == `REG_DATA);
  wire rd_irq  = rd && (addr == `REG_IRQ);

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  wire [7:0] tx_head;
  wire [7:0] rx_head;
  wire       tx_full;
  wire       tx_empty;
  wire       rx_full;
  wire       rx_empty;
  wire       flush = wr_mode && wdata[`MODE_FLUSH];
  wire       load;
  wire       done;
  wire [7:0] rx_byte;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (flush),
    .push  (wr_data),
    .wdata (wdata),
    .pop   (load),
    .rdata (tx_head),
    .full  (tx_full),
    .empty (tx_empty)
  );

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (flush),
    .push  (done),
    .wdata (rx_byte),
    .pop   (rd_data),
    .rdata (rx_head),
    .full  (rx_full),
    .empty (rx_empty)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers and optional glitch filters
  // ----------------------------------------------------------------
  // Bit order: 0 clock, 1 slave data in, 2 master data in, 3 select.
  wire [3:0] pins_in  = {ss_n_in, miso_in, mosi_in, sck_in};
  wire [3:0] filt_on  = {cfg_reg[`CFG_SFLT], {3{cfg_reg[`CFG_DFLT]}}};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= `PINS_IDLE;
      sync2_reg <= `PINS_IDLE;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
    end
  end

  // The filter costs one cycle of latency; a level must hold two samples to pass.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hist_reg[gi] <= PIN_IDLE[gi];
          filt_reg[gi] <= PIN_IDLE[gi];
        end else begin
          hist_reg[gi] <= sync2_reg[gi];
          if (!filt_on[gi] || hist_reg[gi] == sync2_reg[gi]) begin
            filt_reg[gi] <= sync2_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire s_sck  = filt_reg[0];
  wire s_mosi = filt_reg[1];
  wire s_miso = filt_reg[2];
  wire s_ss   = filt_reg[3];

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  wire tick     = (st_reg == ST_MRUN) && (div_reg == half - 8'h01);
  wire sck_chg  = (st_reg == ST_SLAVE) && !s_ss && (s_sck != sck_prev_reg);
  wire lead     = master ? ~edge_reg[0] : (s_sck != cpol);
  wire edge_ev  = master ? tick : sck_chg;
  wire shift_ev = edge_ev && (lead == cpha);
  wire samp_ev  = edge_ev && ((master && cfg_reg[`CFG_SCKE]) ? (lead == cpha) : (lead != cpha));
  wire rx_in    = master ? s_miso : s_mosi;
  wire [7:0] rx_new = shift_in(rx_sh_reg, rx_in, msb);
  wire m_start  = en && master && (st_reg == ST_IDLE) && !tx_empty;
  wire s_start  = en && !master && (st_reg == ST_IDLE) && !s_ss;
  wire m_done   = tick && (edge_reg == `LAST_EDGE);
  wire s_done   = (st_reg == ST_SLAVE) && samp_ev && (bit_reg == `LAST_BIT);
  wire m_more   = m_done && !tx_empty;

  assign done    = en && (m_done || s_done);
  assign rx_byte = samp_ev ? rx_new : rx_sh_reg;
  assign load    = m_start || s_start || m_more || (s_done && en);

  wire [7:0] load_byte = tx_empty ? `IDLE_BYTE : tx_head;
  wire       underrun  = load && tx_empty;
  wire       rx_ovr    = done && rx_full;
  wire       tx_ovr    = wr_data && tx_full;
  wire       thr_hit   = done && (thr_cnt_reg == thr);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= ST_IDLE;
      div_reg      <= 8'h00;
      edge_reg     <= 4'h0;
      bit_reg      <= 3'h0;
      tx_sh_reg    <= 8'h00;
      rx_sh_reg    <= 8'h00;
      out_reg      <= 1'b0;
      phase_reg    <= 1'b0;
      ss_reg       <= 1'b1;
      sck_prev_reg <= 1'b0;
      thr_cnt_reg  <= 2'h0;
    end else begin
      sck_prev_reg <= s_sck;
      if (!en) begin
        st_reg    <= ST_IDLE;
        ss_reg    <= 1'b1;
        phase_reg <= 1'b0;
      end else begin
        if (st_reg == ST_MRUN) begin
          div_reg <= tick ? 8'h00 : div_reg + 8'h01;
        end
        if (tick) begin
          edge_reg  <= edge_reg + 4'h1;
          phase_reg <= ~phase_reg;
        end
        if (samp_ev) begin
          rx_sh_reg <= rx_new;
          bit_reg   <= bit_reg + 3'h1;
        end
        if (load) begin
          if (cpha) begin
            tx_sh_reg <= load_byte;
          end else begin
            out_reg   <= head_bit(load_byte, msb);
            tx_sh_reg <= shift_in(load_byte, 1'b0, msb);
          end
        end else if (shift_ev) begin
          out_reg   <= head_bit(tx_sh_reg, msb);
          tx_sh_reg <= shift_in(tx_sh_reg, 1'b0, msb);
        end
        case (st_reg)
          ST_IDLE: begin
            bit_reg <= 3'h0;
            if (m_start) begin
              st_reg    <= ST_MRUN;
              ss_reg    <= 1'b0;
              div_reg   <= 8'h00;
              edge_reg  <= 4'h0;
              phase_reg <= 1'b0;
            end else if (s_start) begin
              st_reg <= ST_SLAVE;
            end
          end
          ST_MRUN: begin
            if (m_done && !m_more) begin
              st_reg <= ST_IDLE;
              ss_reg <= 1'b1;
            end
          end
          ST_SLAVE: begin
            if (s_ss || master) begin
              st_reg <= ST_IDLE;
            end
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
      if (flush) begin
        thr_cnt_reg <= 2'h0;
      end else if (done) begin
        thr_cnt_reg <= thr_hit ? 2'h0 : thr_cnt_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file and flags
  // ----------------------------------------------------------------
  // A flag event in the same cycle as a software clear keeps the flag set.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg      <= `CFG_RESET;
      mode_reg     <= `MODE_RESET;
      done_reg     <= 1'b0;
      rx_overrun_flag_reg     <= 1'b0;
      tx_overrun_flag_reg     <= 1'b0;
      tx_underrun_flag_reg     <= 1'b0;
      irq_stat_reg <= `IRQ_RESET;
      irq_mask_reg <= `IRQ_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= wdata;
      end
      if (wr_mode) begin
        mode_reg <= wdata & `MODE_WMASK;
      end
      if (wr_mask) begin
        irq_mask_reg <= wdata[3:0];
      end
      if (!en) begin
        done_reg <= 1'b0;
        rx_overrun_flag_reg <= 1'b0;
        tx_overrun_flag_reg <= 1'b0;
        tx_underrun_flag_reg <= 1'b0;
      end else begin
        done_reg <= thr_hit  | (done_reg & ~(wr_stat & ~wdata[`STAT_DONE]));
        rx_overrun_flag_reg <= rx_ovr   | (rx_overrun_flag_reg & ~(wr_stat & ~wdata[`STAT_RX_OVERRUN_FLAG]));
        tx_overrun_flag_reg <= tx_ovr   | (tx_overrun_flag_reg & ~(wr_stat & ~wdata[`STAT_TX_OVERRUN_FLAG]));
        tx_underrun_flag_reg <= underrun | (tx_underrun_flag_reg & ~(wr_stat & ~wdata[`STAT_TX_UNDERRUN_FLAG]));
      end
      irq_stat_reg <= {underrun, tx_ovr, rx_ovr, thr_hit} | (irq_stat_reg & {4{~rd_irq}});
    end
  end

  assign irq = cfg_reg[`CFG_IE] && |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `REG_CFG:  rdata <= cfg_reg;
        `REG_MODE: rdata <= mode_reg;
        `REG_STAT: rdata <= {done_reg, rx_overrun_flag_reg, tx_overrun_flag_reg, tx_underrun_flag_reg,
                             rx_full, rx_empty, tx_full, tx_empty};
        `REG_DATA: rdata <= rx_head;
        `REG_IRQ:  rdata <= {4'h0, irq_stat_reg};
        `REG_MASK: rdata <= {4'h0, irq_mask_reg};
        default:   rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign sck_out  = cpol ^ phase_reg;
  assign sck_oe   = en && master;
  assign mosi_out = out_reg;
  assign mosi_oe  = en && master;
  assign miso_out = out_reg;
  assign miso_oe  = en && !master && !s_ss;
  assign ss_n_out = ss_reg;
  assign ss_n_oe  = en && master;

endmodule // spi_fifo_controller

`default_nettype wire

//--- tb/spi_slave_model.sv
// Behavioural SPI slave facing the controller in master mode.
// Assumes CPOL 0 and CPHA 0: sample on rising, shift on falling.
`timescale 1ns/100ps
`default_nettype none

module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       msb_first,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  logic [7:0] sh = 8'h00;
  logic [2:0] cnt = 3'h0;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  always @(negedge ss_n) begin
    sh = tx_byte;
    cnt = 3'h0;
    miso = msb_first ? sh[7] : sh[0];
  end
  always @(posedge sck) begin
    if (!ss_n) begin
      rx_byte = msb_first ? {rx_byte[6:0], mosi} : {mosi, rx_byte[7:1]};
    end
  end
  // The eighth trailing edge reloads, so back-to-back bytes keep their framing.
  always @(negedge sck) begin
    if (!ss_n) begin
      cnt = cnt + 3'h1;
      sh = (cnt == 3'h0) ? tx_byte : (msb_first ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]});
      miso = msb_first ? sh[7] : sh[0];
    end
  end
  // A released line must not keep looking like valid data.
  always @(posedge ss_n) begin
    miso = ~miso;
  end
endmodule // spi_slave_model

`default_nettype wire

//--- tb/spi_fifo_controller_props.sv
// Port checker for the SPI FIFO controller.
// Assumes it is bound to every instance of the controller; one clock.
`timescale 1ns/100ps
`default_nettype none
`include "spi_defs.vh"

module spi_fifo_controller_props (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       irq,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       ss_n_out,
  input wire logic       ss_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_idle_zero_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (rd && (addr < 8'ha1 || addr > 8'ha6) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  rx_flags_excl_a: assert property (rd && addr == `REG_STAT |=> !(rdata[3] && rdata[2]))
    else $error("receive full and empty together");
  tx_flags_excl_a: assert property (rd && addr == `REG_STAT |=> !(rdata[1] && rdata[0]))
    else $error("transmit full and empty together");
  flush_empties_a: assert property (wr && addr == `REG_MODE && wdata[5] && ss_n_out ##1 !wr && !miso_oe ##1
    rd && addr == `REG_STAT |=> rdata[2] && rdata[0])
    else $error("flush left a fifo occupied");
  flush_reads_zero_a: assert property (rd && addr == `REG_MODE |=> rdata[5:4] == 2'b00)
    else $error("flush bit reads back set");
  sck_half_min_a: assert property (!ss_n_out && $changed(sck_out) |=> $stable(sck_out))
    else $error("serial clock half period below two cycles");
  frame_len_a: assert property ($fell(ss_n_out) |=> !ss_n_out [*8])
    else $error("select pulse too short for a byte");
  oe_excl_a: assert property (!(mosi_oe && miso_oe))
    else $error("both data outputs enabled");
  oe_group_a: assert property (sck_oe == ss_n_oe && mosi_oe == sck_oe)
    else $error("master enables disagree");
  frame_c: cover property ($fell(ss_n_out));
  irq_c: cover property ($rose(irq));
  flush_c: cover property (wr && addr == `REG_MODE && wdata[5]);
endmodule // spi_fifo_controller_props

bind spi_fifo_controller spi_fifo_controller_props props_u (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe),
  .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe));

`default_nettype wire

//--- tb/spi_fifo_controller_tb_top.sv
// Self-checking bench for the SPI FIFO controller.
// Assumes the slave model on the master pins; slave mode is driven here.
`timescale 1ns/100ps
`default_nettype none
`include "spi_defs.vh"

module spi_fifo_controller_tb_top;
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       sck_in = 1'b0, mosi_in = 1'b0, ss_n_in = 1'b1, msb = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, tx_byte = 8'h00, d, got;
  wire logic  irq, sck_out, sck_oe, mosi_out, mosi_oe, miso, miso_out, miso_oe, ss_n_out, ss_n_oe;
  wire logic [7:0] rdata, rx_byte;
  int fail_count = 0, cmp_count = 0, seed = 32'hfa66, i, n, h;

  always #4 clk = ~clk;

  spi_fifo_controller dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe),
    .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe));
  spi_slave_model peer_u (.sck(sck_out), .mosi(mosi_out), .ss_n(ss_n_out), .msb_first(msb),
    .tx_byte(tx_byte), .miso(miso), .rx_byte(rx_byte));

  function automatic int half(input int c);
    return (c == 0) ? 2 : (c == 1) ? 3 : (4 << (c - 2));
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_ss(input logic v);
    for (n = 0; n < 20000 && ss_n_out !== v; n++) @(posedge clk);
    if (n == 20000) begin
      fail_count++;
      results;
    end
  endtask
  task automatic stat(input logic [7:0] exp);
    rreg(`REG_STAT, got);
    chk("status", exp, got);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rreg(`REG_CFG, got);
    chk("cfg reset", 8'h20, got);
    rreg(`REG_MODE, got);
    chk("mode reset", 8'h00, got);
    stat(8'h05);
    wreg(8'ha7, 8'hff);
    rreg(8'ha7, got);
    chk("unmapped", 8'h00, got);
    $display("test reset done");
    // ----------------------------------------------------------------
    // Transmit fill, overrun and flush
    // ----------------------------------------------------------------
    // An idle enabled slave keeps the shifter still while the flags stay live.
    wreg(`REG_CFG, 8'h40);
    wreg(`REG_STAT, 8'h0f);
    stat(8'h05);
    for (i = 0; i < 5; i++) wreg(`REG_DATA, $random(seed));
    stat(8'h26);
    wreg(`REG_STAT, 8'h00);
    stat(8'h06);
    wreg(`REG_MODE, 8'h20);
    stat(8'h05);
    $display("test fifo done");
    // ----------------------------------------------------------------
    // Every rate code with a random bit order and byte
    // ----------------------------------------------------------------
    // Sampling on the shift edge keeps the input synchroniser delay inside one serial period.
    wreg(`REG_CFG, 8'he4);
    for (i = 0; i < 8; i++) begin
      msb = $random(seed);
      tx_byte = $random(seed);
      d = $random(seed);
      wreg(`REG_MODE, {4'h0, i[2:0], msb});
      wreg(`REG_DATA, d);
      wait_ss(1'b0);
      @(negedge clk);
      got = {7'h0, sck_out};
      for (n = 0; n < 600 && sck_out === got[0]; n++) @(negedge clk);
      got = {7'h0, sck_out};
      for (h = 0; h < 600 && sck_out === got[0]; h++) @(negedge clk);
      if (n == 600 || h == 600) begin
        fail_count++;
        results;
      end
      chk("half period", half(i), h[7:0]);
      wait_ss(1'b1);
      chk("sent byte", d, rx_byte);
      rreg(`REG_DATA, got);
      chk("received byte", tx_byte, got);
      stat(8'h85);
      chk("irq masked", 8'h00, {7'h0, irq});
      wreg(`REG_STAT, 8'h00);
      stat(8'h05);
    end
    $display("test rates done");
    // ----------------------------------------------------------------
    // Byte threshold, receive full and receive overrun
    // ----------------------------------------------------------------
    msb = 1'b1;
    wreg(`REG_MODE, 8'he1);
    for (i = 0; i < 3; i++) wreg(`REG_DATA, $random(seed));
    wait_ss(1'b0);
    wait_ss(1'b1);
    stat(8'h01);
    wreg(`REG_DATA, $random(seed));
    wait_ss(1'b0);
    wait_ss(1'b1);
    stat(8'h89);
    wreg(`REG_DATA, $random(seed));
    wait_ss(1'b0);
    wait_ss(1'b1);
    stat(8'hc9);
    for (i = 0; i < 4; i++) begin
      rreg(`REG_DATA, got);
      chk("fifo byte", tx_byte, got);
    end
    wreg(`REG_STAT, 8'h00);
    stat(8'h05);
    $display("test threshold done");
    // ----------------------------------------------------------------
    // Slave select with nothing queued, interrupt raise and clear
    // ----------------------------------------------------------------
    rreg(`REG_IRQ, got);
    wreg(`REG_CFG, 8'hc3);
    wreg(`REG_MASK, 8'h08);
    @(posedge clk);
    ss_n_in <= 1'b0;
    repeat (8) @(posedge clk);
    stat(8'h15);
    chk("irq raised", 8'h01, {7'h0, irq});
    rreg(`REG_IRQ, got);
    chk("irq status", 8'h08, got);
    @(negedge clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    @(posedge clk);
    ss_n_in <= 1'b1;
    $display("test slave done");
    results;
  end
endmodule // spi_fifo_controller_tb_top

`default_nettype wire
